// ==== design/ucd_defs.svh ====
// Shared constants for the serial command decoder and its controller.
// Included by the package; holds definitions only.
`ifndef UCD_DEFS_SVH
`define UCD_DEFS_SVH

// Command byte layout
`define UCD_RSV_BIT 7
`define UCD_AUX_MSB 6
`define UCD_AUX_LSB 4
`define UCD_TC_MSB 3
`define UCD_TC_LSB 2
`define UCD_RC_MSB 1
`define UCD_RC_LSB 0

// Auxiliary command codes
`define UCD_AUX_NONE 3'h0
`define UCD_AUX_RST_PTR 3'h1
`define UCD_AUX_RST_RX 3'h2
`define UCD_AUX_RST_TX 3'h3
`define UCD_AUX_RST_ERR 3'h4
`define UCD_AUX_RST_BRK 3'h5
`define UCD_AUX_START_BRK 3'h6
`define UCD_AUX_STOP_BRK 3'h7

// Transmit and receive command field codes
`define UCD_FLD_ENABLE 2'h1
`define UCD_FLD_DISABLE 2'h2

// Serial status register bit positions
`define UCD_ST_RB 7
`define UCD_ST_FE 6
`define UCD_ST_PE 5
`define UCD_ST_OE 4
`define UCD_ST_TRANSMITTER_EMPTY_FLAG 3
`define UCD_ST_HOLDING_REGISTER_EMPTY_FLAG 2
`define UCD_ST_RECEIVE_FIFO_FULL_FLAG 1
`define UCD_ST_RECEIVE_DATA_AVAILABLE_FLAG 0

// Receiver holding depth, transmit frame length (last bit index)
`define UCD_FIFO_FULL 2'h3
`define UCD_FIFO_EMPTY 2'h0
`define UCD_LAST_BIT 4'h9

// Controller register byte offsets
`define UCD_REG_CMD 8'h00
`define UCD_REG_STATUS 8'h04
`define UCD_REG_INT_STATUS 8'h08
`define UCD_REG_INT_MASK 8'h0C

// Controller status word bit positions
`define UCD_HS_BRKCHG 8
`define UCD_HS_TXEN 9
`define UCD_HS_RXEN 10
`define UCD_HS_MODEPTR 11
`define UCD_HS_BRKON 12

// Interrupt bits
`define UCD_INT_BRKCHG 0
`define UCD_INT_RECEIVE_DATA_AVAILABLE_FLAG 1
`define UCD_INT_HOLDING_REGISTER_EMPTY_FLAG 2
`define UCD_INT_CONFLICT 3
`define UCD_INT_WIDTH 4

`endif

// ==== design/ucd_pkg.sv ====
// Types shared by the command decoder, its controller and their link.
// Assumes ucd_defs.svh is on the include path.
`default_nettype none
`include "ucd_defs.svh"

package ucd_pkg;
  typedef logic [7:0] ucd_byte_t;
  typedef logic [2:0] ucd_aux_t;
  typedef logic [1:0] ucd_fld_t;

  typedef enum logic [2:0]
  {
    UCD_NONE = `UCD_AUX_NONE,
    UCD_RST_PTR = `UCD_AUX_RST_PTR,
    UCD_RST_RX = `UCD_AUX_RST_RX,
    UCD_RST_TX = `UCD_AUX_RST_TX,
    UCD_RST_ERR = `UCD_AUX_RST_ERR,
    UCD_RST_BRK = `UCD_AUX_RST_BRK,
    UCD_START_BRK = `UCD_AUX_START_BRK,
    UCD_STOP_BRK = `UCD_AUX_STOP_BRK
  } ucd_aux_e;

  typedef enum logic [1:0]
  {
    UCD_TX_IDLE = 2'h0,
    UCD_TX_SHIFT = 2'h1,
    UCD_TX_BREAK = 2'h3
  } ucd_tx_e;
endpackage

`default_nettype wire

// ==== design/ucd_link_if.sv ====
// Link between the command-writing controller and the decoder.
// Both ends run on the same mclk; the testbench joins them.
`timescale 1ns/1ps
`default_nettype none

interface ucd_link_if;
  logic cmdStrobe;
  ucd_pkg::ucd_byte_t cmdByte;
  ucd_pkg::ucd_byte_t statusByte;
  logic breakChange;
  logic txEnabled;
  logic rxEnabled;
  logic modePointer;
  logic breakActive;

  modport device
  (
    input cmdStrobe, cmdByte,
    output statusByte, breakChange, txEnabled, rxEnabled, modePointer, breakActive
  );

  modport host
  (
    output cmdStrobe, cmdByte,
    input statusByte, breakChange, txEnabled, rxEnabled, modePointer, breakActive
  );
endinterface

`default_nettype wire

// ==== design/ucd_device.sv ====
// Serial command decoder: decodes one command byte per strobe and keeps
// transmitter, receiver, error and break state of one serial channel.
// Assumes bitTick pulses once per bit time of the selected transmit clock.
`timescale 1ns/1ps
`default_nettype none

module ucd_device
(
  input wire logic mclk,
  input wire logic rstn,
  ucd_link_if.device link,
  input wire logic bitTick,
  input wire logic txLoad,
  input wire ucd_pkg::ucd_byte_t txData,
  input wire logic rxChar,
  input wire logic rxBreakIn,
  input wire logic rxFramingIn,
  input wire logic rxParityIn,
  input wire logic rxRead,
  input wire logic rxBreakChange,
  input wire logic modeAccess,
  input wire logic ctsFlowEnable,
  input wire logic clearToSendN,
  output logic serialTxOut
);
  import ucd_pkg::*;

  ucd_aux_t aux;
  ucd_fld_t txField;
  ucd_fld_t rxField;
  logic isRstPtr, isRstRx, isRstTx, isRstErr, isRstBrk, isStartBrk, isStopBrk;
  logic txEnCmd, txDisCmd, rxEnCmd, rxDisCmd;
  logic txEn, rxEn, holdValid, breakPend, stopReq, modePtr, brkChg;
  ucd_byte_t holdData;
  logic [8:0] shiftReg;
  logic [3:0] bitCnt;
  ucd_tx_e txState;
  logic ctsMeta, ctsSync, ctsOk, startChar, charDone;
  logic [1:0] fifoCount;
  logic rxPush, rxPop, fifoFull;
  logic [3:0] errFlag, errSet;
  logic holding_register_empty_flag, transmitter_empty_flag;

  // Decode lives only in the strobe cycle; nothing of the byte is kept
  assign aux = link.cmdByte[`UCD_AUX_MSB:`UCD_AUX_LSB];
  assign txField = link.cmdByte[`UCD_TC_MSB:`UCD_TC_LSB];
  assign rxField = link.cmdByte[`UCD_RC_MSB:`UCD_RC_LSB];
  assign isRstPtr = link.cmdStrobe && (aux == UCD_RST_PTR);
  assign isRstRx = link.cmdStrobe && (aux == UCD_RST_RX);
  assign isRstTx = link.cmdStrobe && (aux == UCD_RST_TX);
  assign isRstErr = link.cmdStrobe && (aux == UCD_RST_ERR);
  assign isRstBrk = link.cmdStrobe && (aux == UCD_RST_BRK);
  assign isStartBrk = link.cmdStrobe && (aux == UCD_START_BRK);
  assign isStopBrk = link.cmdStrobe && (aux == UCD_STOP_BRK);
  // A reset paired with an enable of the same direction: the reset wins
  assign txEnCmd = link.cmdStrobe && (txField == `UCD_FLD_ENABLE) && !isRstTx;
  assign txDisCmd = link.cmdStrobe && (txField == `UCD_FLD_DISABLE);
  assign rxEnCmd = link.cmdStrobe && (rxField == `UCD_FLD_ENABLE) && !isRstRx;
  assign rxDisCmd = link.cmdStrobe && (rxField == `UCD_FLD_DISABLE);

  // Clear-to-send pin synchroniser
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctsMeta <= 1'b1;
      ctsSync <= 1'b1;
    end
    else
    begin
      ctsMeta <= clearToSendN;
      ctsSync <= ctsMeta;
    end
  end

  assign ctsOk = !ctsFlowEnable || !ctsSync;

  // Mode register pointer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      modePtr <= 1'b0;
    else if (isRstPtr)
      modePtr <= 1'b0;
    else if (modeAccess)
      modePtr <= 1'b1;
  end

  // Transmitter enable
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      txEn <= 1'b0;
    else if (isRstTx || txDisCmd)
      txEn <= 1'b0;
    else if (txEnCmd)
      txEn <= 1'b1;
  end

  assign startChar = bitTick && (txState == UCD_TX_IDLE) && holdValid && txEn
                     && !breakPend && ctsOk;
  assign charDone = bitTick && (txState == UCD_TX_SHIFT) && (bitCnt == `UCD_LAST_BIT);

  // Holding register; writes while not ready are dropped
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      holdValid <= 1'b0;
      holdData <= 8'h00;
    end
    else if (isRstTx || (txEnCmd && !txEn))
      holdValid <= 1'b0;
    else if (startChar)
      holdValid <= 1'b0;
    else if (txLoad && txEn && !holdValid)
    begin
      holdValid <= 1'b1;
      holdData <= txData;
    end
  end

  // Break request: accepted only with the transmitter enabled
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      breakPend <= 1'b0;
    else if (isRstTx || isStopBrk)
      breakPend <= 1'b0;
    else if (isStartBrk && txEn)
      breakPend <= 1'b1;
    else if (txState == UCD_TX_BREAK)
      breakPend <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stopReq <= 1'b0;
    else if (isRstTx || (txState != UCD_TX_BREAK))
      stopReq <= 1'b0;
    else if (isStopBrk)
      stopReq <= 1'b1;
  end

  // Transmit sequencer, stepped by the selected bit clock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      txState <= UCD_TX_IDLE;
    else if (isRstTx)
      txState <= UCD_TX_IDLE;
    else
    begin
      unique case (txState)
        UCD_TX_IDLE:
          // A stop taken in the entry cycle cancels the break; it would be lost otherwise
          if (bitTick && breakPend && !isStopBrk)
            txState <= UCD_TX_BREAK;
          else if (startChar)
            txState <= UCD_TX_SHIFT;
        UCD_TX_SHIFT:
          if (charDone)
            txState <= UCD_TX_IDLE;
        UCD_TX_BREAK:
          if (bitTick && stopReq)
            txState <= UCD_TX_IDLE;
        default:
          txState <= UCD_TX_IDLE;
      endcase
    end
  end

  // Frame shifter: start bit, eight data bits, stop bit
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      shiftReg <= 9'h1FF;
      bitCnt <= 4'h0;
    end
    else if (startChar)
    begin
      shiftReg <= {1'b1, holdData};
      bitCnt <= 4'h0;
    end
    else if (bitTick && (txState == UCD_TX_SHIFT))
    begin
      shiftReg <= {1'b1, shiftReg[8:1]};
      bitCnt <= bitCnt + 4'h1;
    end
  end

  // Line driver; the break holds space until the stop is taken
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      serialTxOut <= 1'b1;
    else if (isRstTx)
      serialTxOut <= 1'b1;
    else if (txState == UCD_TX_IDLE && bitTick && breakPend && !isStopBrk)
      serialTxOut <= 1'b0;
    else if (startChar)
      serialTxOut <= 1'b0;
    else if (bitTick && (txState == UCD_TX_SHIFT))
      serialTxOut <= charDone ? 1'b1 : shiftReg[0];
    else if (bitTick && (txState == UCD_TX_BREAK) && stopReq)
      serialTxOut <= 1'b1;
  end

  assign holding_register_empty_flag = txEn && !holdValid;
  assign transmitter_empty_flag = holding_register_empty_flag && (txState == UCD_TX_IDLE);

  // Receiver enable and holding count
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rxEn <= 1'b0;
    else if (isRstRx || rxDisCmd)
      rxEn <= 1'b0;
    else if (rxEnCmd)
      rxEn <= 1'b1;
  end

  assign fifoFull = (fifoCount == `UCD_FIFO_FULL);
  assign rxPush = rxChar && rxEn && !fifoFull;
  assign rxPop = rxRead && (fifoCount != `UCD_FIFO_EMPTY);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fifoCount <= `UCD_FIFO_EMPTY;
    else if (isRstRx)
      fifoCount <= `UCD_FIFO_EMPTY;
    else if (rxPush && !rxPop)
      fifoCount <= fifoCount + 2'h1;
    else if (rxPop && !rxPush)
      fifoCount <= fifoCount - 2'h1;
  end

  // Error flags: break, framing, parity, overrun; a new error beats the clear
  assign errSet = {rxPush && rxBreakIn, rxPush && rxFramingIn, rxPush && rxParityIn,
                   rxChar && rxEn && fifoFull};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_err
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          errFlag[gi] <= 1'b0;
        else if (errSet[gi])
          errFlag[gi] <= 1'b1;
        else if (isRstErr)
          errFlag[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      brkChg <= 1'b0;
    else if (rxBreakChange)
      brkChg <= 1'b1;
    else if (isRstBrk)
      brkChg <= 1'b0;
  end

  // Registered status towards the controller, one cycle behind the state
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.statusByte <= 8'h00;
      link.breakChange <= 1'b0;
      link.txEnabled <= 1'b0;
      link.rxEnabled <= 1'b0;
      link.modePointer <= 1'b0;
      link.breakActive <= 1'b0;
    end
    else
    begin
      link.statusByte <= {errFlag, transmitter_empty_flag, holding_register_empty_flag, fifoFull, fifoCount != `UCD_FIFO_EMPTY};
      link.breakChange <= brkChg;
      link.txEnabled <= txEn;
      link.rxEnabled <= rxEn;
      link.modePointer <= modePtr;
      link.breakActive <= (txState == UCD_TX_BREAK);
    end
  end
endmodule // ucd_device

`default_nettype wire

// ==== design/ucd_host.sv ====
// Command controller: AHB-Lite slave that forwards command bytes to the
// decoder and reports its status. Zero-wait-state, always OKAY.
`timescale 1ns/1ps
`default_nettype none

module ucd_host
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  ucd_link_if.host link
);
  import ucd_pkg::*;

  logic addrPhase, wrPend;
  logic [7:0] wrAddr;
  logic [`UCD_INT_WIDTH-1:0] intStatus, intMask, intSet;
  logic readIsr;
  logic rxRdyOld, txRdyOld, brkOld;
  ucd_byte_t cleanCmd, lastCmd;
  logic conflict;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && htrans[1] && hready;
  assign readIsr = addrPhase && !hwrite && (haddr[31:0] == {24'h00_0000, `UCD_REG_INT_STATUS});

  // Reserved bit forced low; transmitter enable dropped if paired with its reset
  assign conflict = (hwdata[`UCD_AUX_MSB:`UCD_AUX_LSB] == UCD_RST_TX)
                    && (hwdata[`UCD_TC_MSB:`UCD_TC_LSB] == `UCD_FLD_ENABLE);
  always_comb
  begin
    cleanCmd = hwdata[7:0];
    cleanCmd[`UCD_RSV_BIT] = 1'b0;
    if (conflict)
      cleanCmd[`UCD_TC_MSB:`UCD_TC_LSB] = 2'h0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end
    else
    begin
      wrPend <= addrPhase && hwrite && (haddr[31:8] == 24'h00_0000);
      wrAddr <= haddr[7:0];
    end
  end

  // One strobe per command write, in the cycle after its data phase
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.cmdStrobe <= 1'b0;
      link.cmdByte <= 8'h00;
      lastCmd <= 8'h00;
    end
    else if (wrPend && (wrAddr == `UCD_REG_CMD))
    begin
      link.cmdStrobe <= 1'b1;
      link.cmdByte <= cleanCmd;
      lastCmd <= cleanCmd;
    end
    else
      link.cmdStrobe <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      intMask <= 4'h0;
    else if (wrPend && (wrAddr == `UCD_REG_INT_MASK))
      intMask <= hwdata[`UCD_INT_WIDTH-1:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxRdyOld <= 1'b0;
      txRdyOld <= 1'b0;
      brkOld <= 1'b0;
    end
    else
    begin
      rxRdyOld <= link.statusByte[`UCD_ST_RECEIVE_DATA_AVAILABLE_FLAG];
      txRdyOld <= link.statusByte[`UCD_ST_HOLDING_REGISTER_EMPTY_FLAG];
      brkOld <= link.breakChange;
    end
  end

  always_comb
  begin
    intSet = 4'h0;
    intSet[`UCD_INT_BRKCHG] = link.breakChange && !brkOld;
    intSet[`UCD_INT_RECEIVE_DATA_AVAILABLE_FLAG] = link.statusByte[`UCD_ST_RECEIVE_DATA_AVAILABLE_FLAG] && !rxRdyOld;
    intSet[`UCD_INT_HOLDING_REGISTER_EMPTY_FLAG] = link.statusByte[`UCD_ST_HOLDING_REGISTER_EMPTY_FLAG] && !txRdyOld;
    intSet[`UCD_INT_CONFLICT] = wrPend && (wrAddr == `UCD_REG_CMD) && conflict;
  end

  // Read clears, but an event in the same cycle survives
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      intStatus <= 4'h0;
    else
      intStatus <= (readIsr ? 4'h0 : intStatus) | intSet;
  end

  assign irq = |(intStatus & intMask);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000)
      begin
        unique case (haddr[7:0])
          `UCD_REG_CMD: hrdata <= {24'h00_0000, lastCmd};
          `UCD_REG_STATUS:
            hrdata <= {19'h0_0000, link.breakActive, link.modePointer, link.rxEnabled,
                       link.txEnabled, link.breakChange, link.statusByte};
          `UCD_REG_INT_STATUS: hrdata <= {28'h000_0000, intStatus};
          `UCD_REG_INT_MASK: hrdata <= {28'h000_0000, intMask};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ucd_host

`default_nettype wire

// ==== bench/ucd_sva.sv ====
// Link checker: timing of command effects between controller and decoder.
// Assumes a single mclk domain and that the link signals come in as plain inputs.
`timescale 1ns/1ps
`default_nettype none

module ucd_sva
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmdStrobe,
  input wire ucd_pkg::ucd_byte_t cmdByte,
  input wire ucd_pkg::ucd_byte_t statusByte,
  input wire logic breakChange,
  input wire logic txEnabled,
  input wire logic rxEnabled,
  input wire logic modePointer,
  input wire logic breakActive
);
  import ucd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire ucd_aux_t aux = cmdByte[6:4];
  // A strobe one cycle earlier may already have changed state the link cannot show yet
  logic freshStrobe;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      freshStrobe <= 1'b0;
    else
      freshStrobe <= cmdStrobe;
  end

  a_reserved_bit_clear: assert property (cmdStrobe |-> !cmdByte[7])
    else $error("reserved command bit sent set");
  a_reset_tx_alone: assert property (cmdStrobe && aux == UCD_RST_TX |-> cmdByte[3:2] != 2'h1)
    else $error("transmitter reset sent with enable");
  a_pointer_rewind: assert property (cmdStrobe && aux == UCD_RST_PTR |-> ##2 !modePointer)
    else $error("mode pointer not rewound");
  a_rx_reset: assert property (cmdStrobe && aux == UCD_RST_RX
    |-> ##2 !rxEnabled && statusByte[1:0] == 2'h0)
    else $error("receiver reset incomplete");
  a_tx_reset: assert property (cmdStrobe && aux == UCD_RST_TX
    |-> ##2 !txEnabled && statusByte[3:2] == 2'h0 && !breakActive)
    else $error("transmitter reset incomplete");
  a_error_clear: assert property (cmdStrobe && aux == UCD_RST_ERR |-> ##2 statusByte[7:4] == 4'h0)
    else $error("error flags not cleared");
  a_change_clear: assert property (cmdStrobe && aux == UCD_RST_BRK |-> ##2 !breakChange)
    else $error("break change flag not cleared");
  a_break_refused: assert property (cmdStrobe && aux == UCD_START_BRK && !txEnabled
    && !breakActive && !freshStrobe |=> (!breakActive) [*4])
    else $error("break started with transmitter off");
  a_enable_flags: assert property (cmdStrobe && cmdByte[3:2] == 2'h1 && aux != UCD_RST_TX
    && !txEnabled && !freshStrobe |-> ##2 txEnabled && statusByte[3:2] == 2'h3)
    else $error("transmitter enable incomplete");
endmodule // ucd_sva

`default_nettype wire

// ==== bench/uart_command_decoder_test.sv ====
// Testbench: AHB-Lite master drives the controller, which feeds the decoder.
// Assumes both design ends join through one ucd_link_if; bit time is BIT cycles.
`timescale 1ns/1ps
`default_nettype none

module uart_command_decoder_test;
  import ucd_pkg::*;
  localparam int BIT = 4;
  typedef struct packed {logic [7:0] c; logic [15:0] m; logic [15:0] e;} ucd_row_s;
  localparam ucd_row_s ROWS [10] = '{
    '{8'h05, 16'h060C, 16'h060C}, '{8'h00, 16'h060C, 16'h060C}, '{8'h30, 16'h060C, 16'h0400},
    '{8'h04, 16'h060C, 16'h060C}, '{8'h20, 16'h060F, 16'h020C}, '{8'h01, 16'h060F, 16'h060C},
    '{8'h08, 16'h020C, 16'h0000}, '{8'h34, 16'h020C, 16'h0000}, '{8'h60, 16'h1000, 16'h0000},
    '{8'h84, 16'h020C, 16'h020C}};
  logic mclk, rstn, hsel, hwrite, bitTick, txLoad, rxChar, rxErr, rxRead, rxBreakChange;
  logic modeAccess, ctsFlowEnable, clearToSendN, hreadyout, hresp, irq, serialTxOut;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ucd_byte_t txData;
  int n_fail, compares, tickCount, n;

  ucd_link_if ucd_link_if_inst ();
  ucd_host ucd_host_inst (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .link(ucd_link_if_inst.host));
  ucd_device ucd_device_inst (.mclk(mclk), .rstn(rstn), .link(ucd_link_if_inst.device),
    .bitTick(bitTick), .txLoad(txLoad), .txData(txData), .rxChar(rxChar),
    .rxBreakIn(rxErr), .rxFramingIn(rxErr), .rxParityIn(rxErr), .rxRead(rxRead),
    .rxBreakChange(rxBreakChange), .modeAccess(modeAccess), .ctsFlowEnable(ctsFlowEnable),
    .clearToSendN(clearToSendN), .serialTxOut(serialTxOut));
  ucd_sva ucd_sva_inst (.mclk(mclk), .rstn(rstn), .cmdStrobe(ucd_link_if_inst.cmdStrobe),
    .cmdByte(ucd_link_if_inst.cmdByte), .statusByte(ucd_link_if_inst.statusByte),
    .breakChange(ucd_link_if_inst.breakChange), .txEnabled(ucd_link_if_inst.txEnabled),
    .rxEnabled(ucd_link_if_inst.rxEnabled), .modePointer(ucd_link_if_inst.modePointer),
    .breakActive(ucd_link_if_inst.breakActive));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Free-running bit clock; the selected serial clock is modelled as one tick per BIT
  always @(posedge mclk)
  begin
    tickCount <= (tickCount == BIT - 1) ? 0 : tickCount + 1;
    bitTick <= (tickCount == BIT - 1);
  end

  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("response", 32'h0, hresp);
  endtask

  // Status reaches the link two cycles after the strobe
  task automatic cmd(input logic [7:0] c);
    xfer(1'b1, 32'h0, {24'h0, c});
    repeat (3) @(posedge mclk);
  endtask

  task automatic expect_status(input string what, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, 32'h0000_0004, 32'h0);
    check(what, e, rd & m);
  endtask

  task automatic wait_line(input logic lvl, input int lim);
    n = 0;
    while (serialTxOut !== lvl && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  initial
  begin
    #(100 * 20000);
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    finish_test;
  end

  initial
  begin
    n_fail = 0;
    compares = 0;
    tickCount = 0;
    bitTick = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    txLoad = 1'b0;
    txData = 8'hFF;
    rxChar = 1'b0;
    rxErr = 1'b0;
    rxRead = 1'b0;
    rxBreakChange = 1'b0;
    modeAccess = 1'b0;
    ctsFlowEnable = 1'b0;
    clearToSendN = 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check("line at reset", 32'h1, serialTxOut);
    expect_status("status at reset", 32'h1FFF, 32'h0);
    foreach (ROWS[i])
    begin
      cmd(ROWS[i].c);
      expect_status("command row", {16'h0, ROWS[i].m}, {16'h0, ROWS[i].e});
    end
    xfer(1'b0, 32'h0, 32'h0);
    check("command readback", 32'h0000_0004, rd);
    xfer(1'b1, 32'h0000_0010, 32'h0000_00FF);
    xfer(1'b0, 32'h0000_0010, 32'h0);
    check("unmapped read", 32'h0, rd);
    $display("Test command table done");
    modeAccess <= 1'b1;
    @(posedge mclk);
    modeAccess <= 1'b0;
    repeat (3) @(posedge mclk);
    cmd(8'h00);
    expect_status("pointer kept", 32'h0800, 32'h0800);
    cmd(8'h10);
    expect_status("pointer rewound", 32'h0800, 32'h0);
    $display("Test mode pointer done");
    rxErr <= 1'b1;
    repeat (4)
    begin
      rxChar <= 1'b1;
      @(posedge mclk);
      rxChar <= 1'b0;
      @(posedge mclk);
    end
    rxErr <= 1'b0;
    repeat (3) @(posedge mclk);
    expect_status("errors and fifo", 32'h04F3, 32'h04F3);
    cmd(8'h40);
    expect_status("errors cleared", 32'h04F3, 32'h0403);
    cmd(8'h20);
    expect_status("receiver reset", 32'h04F3, 32'h0);
    $display("Test error flags done");
    check("irq masked", 32'h0, irq);
    xfer(1'b1, 32'h0000_000C, 32'h0000_0001);
    rxBreakChange <= 1'b1;
    @(posedge mclk);
    rxBreakChange <= 1'b0;
    repeat (4) @(posedge mclk);
    check("irq raised", 32'h1, irq);
    cmd(8'h50);
    expect_status("break change cleared", 32'h0100, 32'h0);
    xfer(1'b0, 32'h0000_0008, 32'h0);
    check("event bits", 32'h0000_000F, rd);
    @(posedge mclk);
    check("irq cleared", 32'h0, irq);
    $display("Test interrupt done");
    ctsFlowEnable <= 1'b1;
    clearToSendN <= 1'b1;
    xfer(1'b1, 32'h0, 32'h0000_0060);
    wait_line(1'b0, 8 * BIT);
    check("idle break delay", 32'h1, n <= BIT + 3);
    expect_status("break on", 32'h1000, 32'h1000);
    repeat (3 * BIT) @(posedge mclk);
    check("break held", 32'h0, serialTxOut);
    xfer(1'b1, 32'h0, 32'h0000_0070);
    wait_line(1'b1, 8 * BIT);
    check("stop break delay", 32'h1, n <= 2 * BIT + 3);
    clearToSendN <= 1'b0;
    $display("Test idle break done");
    repeat (2 * BIT) @(posedge mclk);
    txLoad <= 1'b1;
    @(posedge mclk);
    txLoad <= 1'b0;
    wait_line(1'b0, 4 * BIT);
    txData <= 8'h00;
    txLoad <= 1'b1;
    @(posedge mclk);
    txLoad <= 1'b0;
    xfer(1'b1, 32'h0, 32'h0000_0060);
    wait_line(1'b1, 4 * BIT);
    wait_line(1'b0, 16 * BIT);
    check("break after frame", 32'h1, n >= 7 * BIT && n < 16 * BIT);
    xfer(1'b1, 32'h0, 32'h0000_0070);
    wait_line(1'b1, 4 * BIT);
    wait_line(1'b0, 6 * BIT);
    check("held char after break", 32'h1, n < 6 * BIT);
    // Held char is all zeros, so an aborted frame would show as an early mark
    xfer(1'b1, 32'h0, 32'h0000_0008);
    repeat (4 * BIT) @(posedge mclk);
    check("frame kept on disable", 32'h0, serialTxOut);
    wait_line(1'b1, 8 * BIT);
    check("stop bit after disable", 32'h1, n < 8 * BIT);
    expect_status("disabled after frame", 32'h120C, 32'h0);
    $display("Test busy break done");
    rstn <= 1'b0;
    @(posedge mclk);
    check("line in reset", 32'h1, serialTxOut);
    rstn <= 1'b1;
    @(posedge mclk);
    expect_status("status after reset", 32'h1FFF, 32'h0);
    $display("Test second reset done");
    finish_test;
  end
endmodule // uart_command_decoder_test

`default_nettype wire
